// *** common/efcc_map.vh ***
// Register offsets, field positions, reset values and timing counts for the flash controller
`ifndef EFCC_MAP_VH
`define EFCC_MAP_VH
`define EFCC_OFS_RSTCAUSE 16'hA017
`define EFCC_OFS_DATL 16'hA020
`define EFCC_OFS_DATH 16'hA021
`define EFCC_OFS_ADRL 16'hA022
`define EFCC_OFS_ADRH 16'hA023
`define EFCC_OFS_CMD 16'hA025
`define EFCC_CMD_RESET 8'h80
`define EFCC_BIT_VERIFY 7
`define EFCC_BIT_BUSY 6
`define EFCC_BIT_FAIL 5
`define EFCC_BIT_CLEAR 4
`define EFCC_BIT_CKM 3
`define EFCC_BIT_ECC 2
`define EFCC_BIT_WDT 1
`define EFCC_BIT_CMDRST 0
`define EFCC_C_MAIN_READ 5'h10
`define EFCC_C_MAIN_ERASE 5'h08
`define EFCC_C_MAIN_WRITE 5'h04
`define EFCC_C_INFO_READ 5'h02
`define EFCC_C_INFO_WRITE 5'h01
`define EFCC_C_INFO_ERASE 5'h03
`define EFCC_PRESCALE 256
`define EFCC_PAGES 128
`define EFCC_PAGE_WORDS 512
`define EFCC_ZONE_WORDS 1024
`define EFCC_INFO_PAGES 2
`define EFCC_READ_CYCLES 4
`endif

// *** design/efcc_tick.v ***
// Command clock tick generator: system clock divided by 256 and by scaler plus one
`timescale 1ns/100ps
`include "efcc_map.vh"
module efcc_tick (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Control
	input wire run,
	input wire [7:0] scaler,
	// Tick out
	output reg tick
);
	reg [7:0] pre_reg;
	reg [7:0] div_reg;
	always @(posedge clk) begin
		tick <= 1'b0;
		if (rst || !run) begin
			pre_reg <= 8'h00;
			div_reg <= 8'h00;
		end else begin
			pre_reg <= pre_reg + 8'h01;
			if (pre_reg == 8'hFF) begin
				if (div_reg == scaler) begin
					div_reg <= 8'h00;
					tick <= 1'b1;
				end else begin
					div_reg <= div_reg + 8'h01;
				end
			end
		end
	end
endmodule

// *** design/efcc_limit.v ***
// Timeout limit lookup for write and erase commands
`timescale 1ns/100ps
module efcc_limit (
	// Selection
	input wire [2:0] sel,
	input wire erase,
	// Limit in command clock periods
	output reg [13:0] limit
);
	always @* begin
		case ({erase, sel})
			4'h0: limit = 14'd55;
			4'h1: limit = 14'd60;
			4'h2: limit = 14'd65;
			4'h3: limit = 14'd69;
			4'h4: limit = 14'd75;
			4'h5: limit = 14'd80;
			4'h6: limit = 14'd85;
			4'h7: limit = 14'd89;
			4'h8: limit = 14'd5435;
			4'h9: limit = 14'd5953;
			4'hA: limit = 14'd6452;
			4'hB: limit = 14'd6897;
			4'hC: limit = 14'd7408;
			4'hD: limit = 14'd7906;
			4'hE: limit = 14'd8404;
			default: limit = 14'd8889;
		endcase
	end
endmodule

// *** design/efcc_ctrl.v ***
// Embedded flash command controller: registers, command sequencer and array port
`timescale 1ns/100ps
`include "efcc_map.vh"
module efcc_ctrl #(
	parameter ZONES = 64,
	parameter INFO_ZONE = 63
) (
	// Clock and resets
	input wire REF_CLK,
	input wire SRST,
	input wire POR,
	// Special-function register port
	input wire [15:0] SFR_ADDR,
	input wire SFR_WR,
	input wire SFR_RD,
	input wire [7:0] SFR_WDATA,
	output reg [7:0] SFR_RDATA,
	// CPU stall
	output reg CPU_HOLD,
	// Configuration from other blocks
	input wire [7:0] COMMAND_CLOCK_SCALER,
	input wire READ_CORRECTION_ENABLE,
	input wire [ZONES-1:0] ZONE_LOCK_RESETTABLE,
	input wire [ZONES-1:0] ZONE_LOCK_PERMANENT,
	// Reset cause events
	input wire CLOCK_FAULT_EVENT,
	input wire ECC_RESET_EVENT,
	input wire WATCHDOG_EVENT,
	input wire COMMAND_RESET_EVENT,
	// Flash array port
	output reg FL_READ,
	output reg FL_WRITE,
	output reg FL_ERASE,
	output reg FL_INFO,
	output reg [15:0] FL_ADDR,
	output reg [15:0] FL_WDATA,
	input wire [15:0] FL_RDATA,
	input wire [7:0] FL_CORRECTED,
	input wire FL_ECC_ERROR,
	input wire FL_DONE
);
	localparam ST_IDLE = 3'h0;
	localparam ST_READ = 3'h1;
	localparam ST_PROG = 3'h2;
	localparam ST_VERIFY = 3'h3;
	localparam ST_ERASE = 3'h4;
	localparam ST_FINISH = 3'h5;

	reg [2:0] state_reg;
	reg [7:0] datl_reg;
	reg [7:0] dath_reg;
	reg [7:0] adrl_reg;
	reg [7:0] adrh_reg;
	reg [4:0] code_reg;
	reg [2:0] timeout_select_reg;
	reg write_verify_ok_reg;
	reg fail_reg;
	reg clock_fault_cause_flag_reg;
	reg ecc_reset_cause_flag_reg;
	reg watchdog_cause_flag_reg;
	reg command_reset_cause_flag_reg;
	reg [13:0] tcount_reg;
	reg [2:0] rcount_reg;
	wire tick;
	wire [13:0] limit;
	wire [15:0] word_addr;
	wire busy;
	wire cmd_wr;
	wire clr_wr;

	assign word_addr = {adrh_reg, adrl_reg};
	assign busy = (state_reg != ST_IDLE);
	assign cmd_wr = SFR_WR && (SFR_ADDR == `EFCC_OFS_CMD);
	assign clr_wr = SFR_WR && (SFR_ADDR == `EFCC_OFS_RSTCAUSE) && SFR_WDATA[`EFCC_BIT_CLEAR];

	// Command validity and address range check
	function cmd_valid;
		input [4:0] c;
		begin
			case (c)
				`EFCC_C_MAIN_READ, `EFCC_C_MAIN_ERASE, `EFCC_C_MAIN_WRITE,
				`EFCC_C_INFO_READ, `EFCC_C_INFO_WRITE, `EFCC_C_INFO_ERASE: cmd_valid = 1'b1;
				default: cmd_valid = 1'b0;
			endcase
		end
	endfunction

	function is_info;
		input [4:0] c;
		begin
			is_info = (c == `EFCC_C_INFO_READ) || (c == `EFCC_C_INFO_WRITE) ||
				(c == `EFCC_C_INFO_ERASE);
		end
	endfunction

	function addr_ok;
		input [4:0] c;
		input [15:0] a;
		begin
			if (is_info(c))
				addr_ok = (a < `EFCC_INFO_PAGES * `EFCC_PAGE_WORDS);
			else
				addr_ok = (a < `EFCC_PAGES * `EFCC_PAGE_WORDS);
		end
	endfunction

	function zone_open;
		input [4:0] c;
		input [15:0] a;
		reg [5:0] z;
		begin
			z = is_info(c) ? INFO_ZONE[5:0] : a[15:10];
			zone_open = ZONE_LOCK_RESETTABLE[z] && ZONE_LOCK_PERMANENT[z];
		end
	endfunction

	efcc_tick u_tick (
		.clk(REF_CLK),
		.rst(SRST),
		.run(state_reg == ST_PROG || state_reg == ST_ERASE),
		.scaler(COMMAND_CLOCK_SCALER),
		.tick(tick)
	);

	efcc_limit u_limit (
		.sel(timeout_select_reg),
		.erase(state_reg == ST_ERASE),
		.limit(limit)
	);

	// Reset cause flags: set wins over clear; power-on or a clear write clears every flag, SRST clears none
	always @(posedge REF_CLK) begin
		if (POR) begin
			clock_fault_cause_flag_reg <= 1'b0;
			ecc_reset_cause_flag_reg <= 1'b0;
			watchdog_cause_flag_reg <= 1'b0;
			command_reset_cause_flag_reg <= 1'b0;
		end else begin
			if (CLOCK_FAULT_EVENT)
				clock_fault_cause_flag_reg <= 1'b1;
			else if (clr_wr)
				clock_fault_cause_flag_reg <= 1'b0;
			if (ECC_RESET_EVENT)
				ecc_reset_cause_flag_reg <= 1'b1;
			else if (clr_wr)
				ecc_reset_cause_flag_reg <= 1'b0;
			if (WATCHDOG_EVENT)
				watchdog_cause_flag_reg <= 1'b1;
			else if (clr_wr)
				watchdog_cause_flag_reg <= 1'b0;
			if (COMMAND_RESET_EVENT)
				command_reset_cause_flag_reg <= 1'b1;
			else if (clr_wr)
				command_reset_cause_flag_reg <= 1'b0;
		end
	end

	// Register writes, sequencer and array strobes
	always @(posedge REF_CLK) begin
		if (SRST) begin
			state_reg <= ST_IDLE;
			datl_reg <= 8'h00;
			dath_reg <= 8'h00;
			adrl_reg <= 8'h00;
			adrh_reg <= 8'h00;
			code_reg <= 5'h00;
			timeout_select_reg <= 3'h0;
			write_verify_ok_reg <= 1'b1;
			fail_reg <= 1'b0;
			tcount_reg <= 14'h0000;
			rcount_reg <= 3'h0;
			CPU_HOLD <= 1'b0;
			FL_READ <= 1'b0;
			FL_WRITE <= 1'b0;
			FL_ERASE <= 1'b0;
			FL_INFO <= 1'b0;
			FL_ADDR <= 16'h0000;
			FL_WDATA <= 16'h0000;
		end else begin
			FL_READ <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (SFR_WR && SFR_ADDR == `EFCC_OFS_DATL)
						datl_reg <= SFR_WDATA;
					if (SFR_WR && SFR_ADDR == `EFCC_OFS_DATH)
						dath_reg <= SFR_WDATA;
					if (SFR_WR && SFR_ADDR == `EFCC_OFS_ADRL)
						adrl_reg <= SFR_WDATA;
					if (SFR_WR && SFR_ADDR == `EFCC_OFS_ADRH)
						adrh_reg <= SFR_WDATA;
					if (cmd_wr) begin
						code_reg <= SFR_WDATA[4:0];
						timeout_select_reg <= SFR_WDATA[7:5];
						write_verify_ok_reg <= 1'b1;
						fail_reg <= 1'b0;
						tcount_reg <= 14'h0000;
						rcount_reg <= 3'h0;
						FL_ADDR <= word_addr;
						FL_WDATA <= {dath_reg, datl_reg};
						FL_INFO <= is_info(SFR_WDATA[4:0]);
						if (!cmd_valid(SFR_WDATA[4:0])) begin
							fail_reg <= 1'b1;
						end else if (!addr_ok(SFR_WDATA[4:0], word_addr)) begin
							fail_reg <= 1'b1;
						end else if (SFR_WDATA[4:0] == `EFCC_C_MAIN_READ ||
							SFR_WDATA[4:0] == `EFCC_C_INFO_READ) begin
							state_reg <= ST_READ;
							FL_READ <= 1'b1;
							CPU_HOLD <= 1'b1;
						end else if (!zone_open(SFR_WDATA[4:0], word_addr)) begin
							fail_reg <= 1'b1;
						end else if (SFR_WDATA[4:0] == `EFCC_C_MAIN_WRITE ||
							SFR_WDATA[4:0] == `EFCC_C_INFO_WRITE) begin
							state_reg <= ST_PROG;
							FL_WRITE <= 1'b1;
							CPU_HOLD <= 1'b1;
						end else begin
							state_reg <= ST_ERASE;
							FL_ADDR <= {word_addr[15:9], 9'h000};
							FL_ERASE <= 1'b1;
							CPU_HOLD <= 1'b1;
						end
					end
				end
				ST_READ: begin
					rcount_reg <= rcount_reg + 3'h1;
					if (rcount_reg == `EFCC_READ_CYCLES - 1) begin
						dath_reg <= FL_RDATA[15:8];
						datl_reg <= READ_CORRECTION_ENABLE ? FL_CORRECTED : FL_RDATA[7:0];
						if (FL_ECC_ERROR)
							fail_reg <= 1'b1;
						state_reg <= ST_FINISH;
					end
				end
				ST_PROG, ST_ERASE: begin
					if (tick)
						tcount_reg <= tcount_reg + 14'h0001;
					if (FL_DONE) begin
						FL_WRITE <= 1'b0;
						FL_ERASE <= 1'b0;
						if (state_reg == ST_PROG) begin
							state_reg <= ST_VERIFY;
							FL_READ <= 1'b1;
						end else begin
							state_reg <= ST_FINISH;
						end
					end else if (tcount_reg >= limit) begin
						FL_WRITE <= 1'b0;
						FL_ERASE <= 1'b0;
						fail_reg <= 1'b1;
						state_reg <= ST_FINISH;
					end
				end
				ST_VERIFY: begin
					rcount_reg <= rcount_reg + 3'h1;
					if (rcount_reg == `EFCC_READ_CYCLES - 1) begin
						if (FL_RDATA != FL_WDATA)
							write_verify_ok_reg <= 1'b0;
						state_reg <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					CPU_HOLD <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Read data; busy blocks nothing on reads, fail unaffected by reads
	always @(posedge REF_CLK) begin
		if (SRST) begin
			SFR_RDATA <= 8'h00;
		end else if (SFR_RD) begin
			case (SFR_ADDR)
				`EFCC_OFS_RSTCAUSE: SFR_RDATA <= {4'h0, clock_fault_cause_flag_reg,
					ecc_reset_cause_flag_reg, watchdog_cause_flag_reg,
					command_reset_cause_flag_reg};
				`EFCC_OFS_DATL: SFR_RDATA <= datl_reg;
				`EFCC_OFS_DATH: SFR_RDATA <= dath_reg;
				`EFCC_OFS_ADRL: SFR_RDATA <= adrl_reg;
				`EFCC_OFS_ADRH: SFR_RDATA <= adrh_reg;
				`EFCC_OFS_CMD: SFR_RDATA <= {write_verify_ok_reg, busy, fail_reg, code_reg};
				default: SFR_RDATA <= 8'h00;
			endcase
		end
	end
endmodule

// *** tb/efcc_chk_asserts.sv ***
// Port assertions for the flash command controller
`timescale 1ns/100ps
`include "efcc_map.vh"
module efcc_chk (
	// Clock and reset
	input wire REF_CLK,
	input wire SRST,
	// Register port
	input wire [15:0] SFR_ADDR,
	input wire SFR_WR,
	input wire [7:0] SFR_WDATA,
	// Stall and array port
	input wire CPU_HOLD,
	input wire FL_READ,
	input wire FL_WRITE,
	input wire FL_ERASE,
	input wire FL_INFO,
	input wire [15:0] FL_ADDR,
	input wire FL_DONE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	wire cw = SFR_WR && SFR_ADDR == `EFCC_OFS_CMD && !CPU_HOLD;
	wire [4:0] c = SFR_WDATA[4:0];
	property p_rd_go;
		cw && c == `EFCC_C_MAIN_READ |=> CPU_HOLD && FL_READ && !FL_INFO;
	endproperty
	a_rd_go: assert property (p_rd_go) else $error("read start");
	property p_rd_len;
		$rose(CPU_HOLD) && FL_READ |-> CPU_HOLD [*5] ##1 !CPU_HOLD;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read length");
	property p_bad;
		cw && !(c inside {5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03})
		|=> (!CPU_HOLD && !FL_WRITE && !FL_ERASE) [*3];
	endproperty
	a_bad: assert property (p_bad) else $error("invalid code ran");
	property p_wr_end;
		FL_WRITE && FL_DONE |=> !FL_WRITE && FL_READ && CPU_HOLD;
	endproperty
	a_wr_end: assert property (p_wr_end) else $error("write end");
	property p_er_end;
		FL_ERASE && FL_DONE |=> !FL_ERASE ##[0:2] !CPU_HOLD;
	endproperty
	a_er_end: assert property (p_er_end) else $error("erase end");
	property p_hold;
		FL_WRITE || FL_ERASE |-> CPU_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("cpu not held");
	property p_page;
		FL_ERASE |-> FL_ADDR[8:0] == 9'h000;
	endproperty
	a_page: assert property (p_page) else $error("erase not page");
	property p_excl;
		FL_WRITE |-> !FL_ERASE;
	endproperty
	a_excl: assert property (p_excl) else $error("write and erase");
	property p_pulse;
		FL_READ |=> !FL_READ;
	endproperty
	a_pulse: assert property (p_pulse) else $error("read pulse");
endmodule
bind efcc_ctrl efcc_chk u_chk (.REF_CLK(REF_CLK), .SRST(SRST), .SFR_ADDR(SFR_ADDR),
	.SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .CPU_HOLD(CPU_HOLD), .FL_READ(FL_READ),
	.FL_WRITE(FL_WRITE), .FL_ERASE(FL_ERASE), .FL_INFO(FL_INFO), .FL_ADDR(FL_ADDR),
	.FL_DONE(FL_DONE));

// *** tb/efcc_fm.sv ***
// Flash array model answering the controller's array port
`timescale 1ns/100ps
module efcc_fm (
	// Clock
	input wire clk,
	// Array port
	input wire rd,
	input wire wr,
	input wire er,
	input wire [15:0] addr,
	input wire [15:0] wdata,
	output reg [15:0] rdata,
	output reg [7:0] corr,
	output reg ecc_err,
	output reg done,
	// Fault controls
	input wire stall,
	input wire bad,
	input wire inj
);
	reg [15:0] mem [0:15];
	reg [2:0] cnt;
	integer i;
	initial begin
		for (i = 0; i < 16; i = i + 1)
			mem[i] = 16'h5A00 + i;
		cnt = 0;
		done = 0;
	end
	always @(posedge clk) begin
		done <= 1'b0;
		cnt <= ((wr | er) && !stall && !done) ? cnt + 3'h1 : 3'h0;
		if (cnt == 3'h3 && !done) begin
			done <= 1'b1;
			if (wr)
				mem[addr[3:0]] <= wdata ^ {15'h0, bad};
			if (er)
				for (i = 0; i < 16; i = i + 1)
					mem[i] <= 16'hFFFF;
		end
		if (rd) begin
			rdata <= mem[addr[3:0]];
			corr <= ~mem[addr[3:0]][7:0];
			ecc_err <= inj;
		end
	end
endmodule

// *** tb/embedded_flash_command_controller_tb.sv ***
// Self-checking testbench for the flash command controller
`timescale 1ns/100ps
`include "efcc_map.vh"
module embedded_flash_command_controller_tb;
	reg clk, srst, por, s_wr, s_rd, ce, stall, bad, inj;
	reg [7:0] scl;
	reg [15:0] adr;
	reg [7:0] wd;
	reg [3:0] ev;
	reg [63:0] zr, zp;
	wire [7:0] rdat, fcor;
	wire hold, frd, fwr, fer, fdn, fecc;
	wire [15:0] fa, fw, frdat;
	integer fails, cmp_count, i, n, tl;
	efcc_ctrl dut_u (.REF_CLK(clk), .SRST(srst), .POR(por), .SFR_ADDR(adr), .SFR_WR(s_wr),
		.SFR_RD(s_rd), .SFR_WDATA(wd), .SFR_RDATA(rdat), .CPU_HOLD(hold),
		.COMMAND_CLOCK_SCALER(scl), .READ_CORRECTION_ENABLE(ce),
		.ZONE_LOCK_RESETTABLE(zr), .ZONE_LOCK_PERMANENT(zp), .CLOCK_FAULT_EVENT(ev[3]),
		.ECC_RESET_EVENT(ev[2]), .WATCHDOG_EVENT(ev[1]), .COMMAND_RESET_EVENT(ev[0]),
		.FL_READ(frd), .FL_WRITE(fwr), .FL_ERASE(fer), .FL_INFO(), .FL_ADDR(fa),
		.FL_WDATA(fw), .FL_RDATA(frdat), .FL_CORRECTED(fcor), .FL_ECC_ERROR(fecc),
		.FL_DONE(fdn));
	efcc_fm fm_u (.clk(clk), .rd(frd), .wr(fwr), .er(fer), .addr(fa), .wdata(fw),
		.rdata(frdat), .corr(fcor), .ecc_err(fecc), .done(fdn), .stall(stall),
		.bad(bad), .inj(inj));
	task print_verdict;
		begin
			$display("fails %0d cmp_count %0d", fails, cmp_count);
			if (fails == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input string nm, input [15:0] e, input [15:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("mismatch %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		begin
			@(posedge clk);
			adr <= a;
			wd <= d;
			s_wr <= 1'b1;
			@(posedge clk);
			s_wr <= 1'b0;
		end
	endtask
	task rc(input [15:0] a, input [7:0] e);
		begin
			@(posedge clk);
			adr <= a;
			s_rd <= 1'b1;
			@(posedge clk);
			s_rd <= 1'b0;
			#1;
			chk($sformatf("reg %h", a), e, rdat);
		end
	endtask
	task rs(input [2:0] e);
		begin
			@(posedge clk);
			adr <= `EFCC_OFS_CMD;
			s_rd <= 1'b1;
			@(posedge clk);
			s_rd <= 1'b0;
			#1;
			chk("status", e, rdat[7:5]);
		end
	endtask
	task op(input [7:0] c, input [15:0] a, input [15:0] d, input [2:0] e);
		begin
			wr(`EFCC_OFS_ADRL, a[7:0]);
			wr(`EFCC_OFS_ADRH, a[15:8]);
			wr(`EFCC_OFS_DATL, d[7:0]);
			wr(`EFCC_OFS_DATH, d[15:8]);
			wr(`EFCC_OFS_CMD, c);
			n = 0;
			@(posedge clk);
			#1;
			while (hold === 1'b1 && n < 30000) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			if (hold !== 1'b0) begin
				fails = fails + 1;
				$display("mismatch hold exp 0 got %b", hold);
			end
			rs(e);
		end
	endtask
	task t_reset;
		begin
			rc(`EFCC_OFS_CMD, 8'h80);
			rc(`EFCC_OFS_DATH, 8'h00);
			rc(`EFCC_OFS_ADRL, 8'h00);
			rc(16'hA024, 8'h00);
			rc(`EFCC_OFS_RSTCAUSE, 8'h00);
		end
	endtask
	task t_read;
		begin
			ce <= 1'b1;
			op(8'hF0, 16'h0005, 16'h0000, 3'b100);
			rc(`EFCC_OFS_CMD, 8'h90);
			rc(`EFCC_OFS_DATL, 8'hFA);
			rc(`EFCC_OFS_DATH, 8'h5A);
			ce <= 1'b0;
			op(8'hE2, 16'h0005, 16'h0000, 3'b100);
			rc(`EFCC_OFS_DATL, 8'h05);
			inj <= 1'b1;
			op(8'hF0, 16'h0005, 16'h0000, 3'b101);
			inj <= 1'b0;
			rs(3'b101);
		end
	endtask
	task t_write;
		begin
			op(8'hE4, 16'h0002, 16'h1234, 3'b100);
			op(8'hF0, 16'h0002, 16'h0000, 3'b100);
			rc(`EFCC_OFS_DATH, 8'h12);
			bad <= 1'b1;
			op(8'hE4, 16'h0002, 16'h1234, 3'b000);
			bad <= 1'b0;
			rs(3'b000);
			op(8'hE1, 16'h0003, 16'h0000, 3'b100);
			wr(`EFCC_OFS_CMD, 8'hE4);
			rs(3'b110);
			wr(`EFCC_OFS_DATL, 8'hAA);
			wait (hold === 1'b0);
			rc(`EFCC_OFS_DATL, 8'h00);
		end
	endtask
	task t_guard;
		begin
			zr <= 64'hFFFFFFFFFFFFFFFE;
			op(8'hE4, 16'h0001, 16'h0000, 3'b101);
			zr <= 64'hFFFFFFFFFFFFFFFF;
			zp <= 64'h7FFFFFFFFFFFFFFF;
			op(8'hE3, 16'h0000, 16'h0000, 3'b101);
			zp <= 64'hFFFFFFFFFFFFFFFF;
			op(8'hE1, 16'h0400, 16'h0000, 3'b101);
			op(8'hE0, 16'h0000, 16'h0000, 3'b101);
			op(8'hFF, 16'h0000, 16'h0000, 3'b101);
		end
	endtask
	task t_erase;
		begin
			op(8'hE8, 16'h0205, 16'h0000, 3'b100);
			op(8'hF0, 16'h0005, 16'h0000, 3'b100);
			rc(`EFCC_OFS_DATL, 8'hFF);
			op(8'hE3, 16'h0003, 16'h0000, 3'b100);
		end
	endtask
	task t_tmo;
		begin
			stall <= 1'b1;
			for (i = 0; i < 3; i = i + 1) begin
				scl <= (i == 2) ? 8'h01 : 8'h00;
				op({(i == 1) ? 3'h7 : 3'h0, 5'h04}, 16'h0001, 16'h0000, 3'b101);
				tl = (i == 1) ? 89 * 256 : (i == 2) ? 55 * 512 : 55 * 256;
				chk("timeout", tl[15:0], n[15:0] & 16'hFF00);
			end
			scl <= 8'h00;
			stall <= 1'b0;
		end
	endtask
	task t_cause;
		begin
			@(posedge clk);
			ev <= 4'hF;
			@(posedge clk);
			ev <= 4'h0;
			rc(`EFCC_OFS_RSTCAUSE, 8'h0F);
			@(posedge clk);
			srst <= 1'b1;
			@(posedge clk);
			srst <= 1'b0;
			rc(`EFCC_OFS_RSTCAUSE, 8'h0F);
			ev <= 4'hF;
			@(posedge clk);
			ev <= 4'h0;
			wr(`EFCC_OFS_RSTCAUSE, 8'h10);
			rc(`EFCC_OFS_RSTCAUSE, 8'h00);
		end
	endtask
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		#3600000;
		fails = fails + 1;
		print_verdict;
	end
	initial begin
		{srst, s_wr, s_rd, ce, stall, bad, inj} = 7'b1000000;
		por = 1'b1;
		scl = 8'h00;
		adr = 0;
		wd = 0;
		ev = 0;
		zr = {64{1'b1}};
		zp = {64{1'b1}};
		fails = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		por <= 1'b0;
		t_reset;
		t_read;
		t_write;
		t_guard;
		t_erase;
		t_tmo;
		t_cause;
		print_verdict;
	end
endmodule
